// ===== pph_host_port.sv
// Host-facing parallel port: select, strobe latch, acknowledge and busy.
`timescale 1ns/1ps
`include "pph_consts.svh"
module pph_host_port
#(
   parameter int ACK_CYCLES = `PPH_ACK_CYC,
   parameter bit HAS_SYNC_CHECK = 1'b1,
   parameter bit HAS_MEM_CHECK = 1'b1
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] host_data_n,
   input wire logic host_strobe_n,
   input wire logic host_init_prime_n,
   input wire logic init_prime_enable_switch,
   input wire logic online_switch,
   input wire logic alarm_clear_switch,
   input wire logic test_switch,
   input wire logic busy_set,
   input wire logic busy_release,
   input wire logic user_port_enable_n,
   input wire logic user_latch_read_decode_n,
   input wire logic control_group_zero_decode_n,
   input wire logic [2:0] addr_10_12,
   input wire logic [7:0] tape_line_count,
   input wire logic tape_load_done,
   input wire logic [7:0] direct_line_count,
   input wire logic direct_load_active,
   input wire logic direct_tof_error,
   input wire logic direct_data_error,
   input wire logic alternate_line_skip_mode,
   input wire logic print_sync_lost,
   input wire logic memory_error,
   output logic busy,
   output logic data_demand_n,
   output logic ack_n,
   output logic selected_indication,
   output logic fault_n,
   output logic paper_empty,
   output logic [7:0] register_bus,
   output logic register_bus_oe_n,
   output logic data_ready,
   output logic init_printer,
   output logic [7:0] status_code
);
   logic [7:0] data_s;
   logic strobe_n_s;
   logic prime_n_s;
   logic [2:0] sw_s;
   logic [2:0] sw_q_ff;
   logic strobe_q_ff;
   logic [7:0] latch_ff;
   logic busy_ff;
   logic pe_ff;
   logic ready_ff;
   logic prime_q_ff;
   logic [15:0] ack_cnt_ff;
   pph_pkg::pph_mode_t mode_ff;
   pph_pkg::pph_mode_t nxt_mode;
   pph_pkg::pph_ack_t ack_ff;
   pph_pkg::pph_ack_t nxt_ack;
   logic fault;
   initial
   begin
      if (ACK_CYCLES < 1 || ACK_CYCLES > 65535)
      begin
         $error("pph_host_port acknowledge length out of range.");
      end
   end
   pph_sync #(.WIDTH(10), .RESET_VAL(10'h3ff)) u_sync_host
   (
      .clock(clock),
      .rst(rst),
      .async_in({host_data_n, host_strobe_n, host_init_prime_n}),
      .sync_out({data_s, strobe_n_s, prime_n_s})
   );
   pph_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_sync_sw
   (
      .clock(clock),
      .rst(rst),
      .async_in({online_switch, alarm_clear_switch, test_switch}),
      .sync_out(sw_s)
   );
   wire [7:0] data_true = ~data_s; // [R8]
   wire strobe_fall = strobe_q_ff && !strobe_n_s;
   wire online_press = sw_s[2] && !sw_q_ff[2];
   wire clear_press = sw_s[1] && !sw_q_ff[1];
   wire prime_fall = prime_q_ff && !prime_n_s;
   wire in_test = (mode_ff == pph_pkg::PPH_SELFTEST);
   wire selected = (mode_ff == pph_pkg::PPH_ONLINE);
   // Self-test drops every strobe, including the select code.
   wire latch_load_strobe = strobe_fall && !in_test; // [R20]
   wire is_select = latch_load_strobe && (data_true == `PPH_SELECT_CODE); // [R5]
   wire remote_select = is_select && !fault && !in_test; // [R6] [R24]
   wire is_deselect = latch_load_strobe && selected && (data_true == `PPH_DESELECT_CODE);
   // Busy is not checked here: the select code must get through while busy.
   wire data_accept = latch_load_strobe && selected && !is_deselect; // [R3]
   wire prime_act = prime_fall && init_prime_enable_switch; // [R9]
   wire clear_act = clear_press || prime_act; // [R10]
   wire skip_seen = data_accept && (data_true == `PPH_FMT_PREFIX_CODE);
   wire bus_drive = !user_port_enable_n && !user_latch_read_decode_n; // [R11]
   wire [2:0] pe_addr = `PPH_PE_ADDR;
   // Address line 10 carries the new level, so only lines 11 and 12 take part in the decode.
   wire pe_hit = !control_group_zero_decode_n && (addr_10_12[2:1] == pe_addr[2:1]); // [R2]
   wire ack_done = (ack_cnt_ff == 16'(ACK_CYCLES - 1));
   pph_status #(.HAS_SYNC_CHECK(HAS_SYNC_CHECK), .HAS_MEM_CHECK(HAS_MEM_CHECK)) u_status
   (
      .clock(clock),
      .rst(rst),
      .clear(clear_act),
      .tape_line_count(tape_line_count),
      .tape_load_done(tape_load_done),
      .direct_line_count(direct_line_count),
      .direct_load_active(direct_load_active),
      .direct_tof_error(direct_tof_error),
      .direct_data_error(direct_data_error),
      .skip_prefix_seen(skip_seen),
      .alternate_line_skip_mode(alternate_line_skip_mode),
      .print_sync_lost(print_sync_lost),
      .memory_error(memory_error),
      .status_code(status_code),
      .fault(fault)
   );
   always_comb
   begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         pph_pkg::PPH_OFFLINE:
         begin
            if (sw_s[0])
            begin
               nxt_mode = pph_pkg::PPH_SELFTEST;
            end
            else if (online_press || remote_select)
            begin
               nxt_mode = pph_pkg::PPH_ONLINE; // [R4]
            end
         end
         pph_pkg::PPH_ONLINE:
         begin
            // The test control is not looked at while selected.
            if (online_press || is_deselect) // [R22]
            begin
               nxt_mode = pph_pkg::PPH_OFFLINE;
            end
         end
         pph_pkg::PPH_SELFTEST:
         begin
            if (!sw_s[0] && online_press)
            begin
               nxt_mode = pph_pkg::PPH_OFFLINE; // [R21]
            end
         end
         default:
         begin
            nxt_mode = pph_pkg::PPH_OFFLINE;
         end
      endcase
   end
   always_comb
   begin
      nxt_ack = ack_ff;
      unique case (ack_ff)
         pph_pkg::PPH_ACK_IDLE:
         begin
            if (data_accept || remote_select)
            begin
               nxt_ack = pph_pkg::PPH_ACK_WAIT; // [R12]
            end
         end
         pph_pkg::PPH_ACK_WAIT:
         begin
            if (!busy_ff && !busy_set)
            begin
               nxt_ack = pph_pkg::PPH_ACK_PULSE; // [R13]
            end
         end
         pph_pkg::PPH_ACK_PULSE:
         begin
            if (ack_done)
            begin
               nxt_ack = pph_pkg::PPH_ACK_IDLE;
            end
         end
         default:
         begin
            nxt_ack = pph_pkg::PPH_ACK_IDLE;
         end
      endcase
   end
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         mode_ff <= pph_pkg::PPH_OFFLINE;
         ack_ff <= pph_pkg::PPH_ACK_IDLE;
         ack_cnt_ff <= 16'h0;
         strobe_q_ff <= 1'b1;
         prime_q_ff <= 1'b1;
         sw_q_ff <= 3'h0;
         latch_ff <= 8'h0;
         busy_ff <= 1'b1; // [R23]
         pe_ff <= 1'b1; // [R23]
         ready_ff <= 1'b0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         ack_ff <= nxt_ack;
         ack_cnt_ff <= (ack_ff == pph_pkg::PPH_ACK_PULSE) ? ack_cnt_ff + 16'h1 : 16'h0;
         strobe_q_ff <= strobe_n_s;
         prime_q_ff <= prime_n_s;
         sw_q_ff <= sw_s;
         if (latch_load_strobe)
         begin
            latch_ff <= data_true; // [R8]
         end
         // Busy set by a new byte wins over a release in the same cycle.
         busy_ff <= busy_set || data_accept ? 1'b1 : ((busy_release || clear_act) ? 1'b0 : busy_ff);
         if (pe_hit)
         begin
            pe_ff <= addr_10_12[0];
         end
         ready_ff <= data_accept ? 1'b1 : (bus_drive ? 1'b0 : ready_ff);
      end
   end
   assign busy = busy_ff || in_test; // [R1] [R19]
   assign data_demand_n = busy; // [R1]
   assign ack_n = (ack_ff != pph_pkg::PPH_ACK_PULSE);
   assign selected_indication = selected; // [R7]
   assign fault_n = !(fault || in_test); // [R19]
   assign paper_empty = pe_ff; // [R2]
   assign register_bus = latch_ff;
   assign register_bus_oe_n = !bus_drive; // [R11]
   assign data_ready = ready_ff;
   assign init_printer = clear_act; // [R9] [R10]
endmodule

// ===== pph_consts.svh
// Constants for the parallel printer host port.
// Interface rules this block is built around
// [R1] Busy latch set drives busy to host and drops data demand together.
// [R2] Paper empty comes from control group zero decode with address lines 10-12.
// [R3] Print and format data are refused until the port is selected.
// [R4] Selection happens by operator on-line toggle or by a select code from host.
// [R5] Host byte 11 hex is recognised as the remote select code.
// [R6] Remote select code is accepted even while busy is asserted.
// [R7] Selected indication is asserted to the host once selected.
// [R8] Host data is inverted and loaded into the latch by the latch load strobe.
// [R9] Init prime clears buffer and initialises only when its enable switch is on.
// [R10] Host init prime acts exactly like the operator alarm/clear control.
// [R11] Latched byte drives the register bus only while both read decodes are active.
// [R12] An acknowledge pulse goes to the host after each received byte; the code sends none after the deselect code 13 hex.
// [R13] If a byte causes busy, acknowledge waits until busy is released.
// [R14] Status code 13 when a loaded format tape exceeds 126 lines.
// [R15] Status code 27 when a direct-access format load exceeds 126 lines.
// [R16] Status 29 on top-of-form error, 31 on data error, in direct-access load.
// [R17] Status 32 when a format-skip prefix arrives in alternate line-skip mode.
// [R18] Status 17 on print sync loss, 34 on memory error, where supported.
// [R19] In self-test, busy and fault to the host are held asserted.
// [R20] In self-test, host strobe pulses are ignored completely.
// [R21] Self-test exits on centred test control plus on/off press, then off line.
// [R22] Once selected, the self-test control input is disregarded.
// [R23] At power up only busy and paper empty are asserted toward the host.
// [R24] Remote select acts only with no fault and not in self-test.
// [R25] Host holds data stable during strobe and waits for acknowledge.
`ifndef PPH_CONSTS_SVH
`define PPH_CONSTS_SVH
`define PPH_SELECT_CODE 8'h11
`define PPH_DESELECT_CODE 8'h13
`define PPH_FMT_PREFIX_CODE 8'h1f
`define PPH_MAX_FORMAT_LINES 8'h7e
`define PPH_ST_NONE 8'h00
`define PPH_ST_TAPE_LONG 8'h13
`define PPH_ST_SYNC_LOSS 8'h17
`define PPH_ST_DA_LONG 8'h27
`define PPH_ST_DA_TOF 8'h29
`define PPH_ST_DA_DATA 8'h31
`define PPH_ST_SKIP_IN_ALT 8'h32
`define PPH_ST_MEM_ERR 8'h34
`define PPH_PE_ADDR 3'h7
`define PPH_ACK_NS 5000
`define PPH_CLK_NS 10
`define PPH_ACK_CYC ((`PPH_ACK_NS + `PPH_CLK_NS - 1) / `PPH_CLK_NS)
`define PPH_SYNC_RESET 2'h0
`endif

// ===== pph_pkg.sv
// Types shared by the parallel printer host port.
package pph_pkg;
   typedef enum logic [1:0]
   {
      PPH_OFFLINE = 2'b00,
      PPH_ONLINE = 2'b01,
      PPH_SELFTEST = 2'b10
   } pph_mode_t;
   typedef enum logic [1:0]
   {
      PPH_ACK_IDLE = 2'b00,
      PPH_ACK_WAIT = 2'b01,
      PPH_ACK_PULSE = 2'b10
   } pph_ack_t;
endpackage

// ===== pph_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
module pph_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   initial
   begin
      if (WIDTH < 1)
      begin
         $error("pph_sync width must be positive.");
      end
   end
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta_ff <= RESET_VAL;
         sync_ff <= RESET_VAL;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end
   assign sync_out = sync_ff;
endmodule

// ===== pph_status.sv
// Status code selection for format-unit and printer faults.
`timescale 1ns/1ps
`include "pph_consts.svh"
module pph_status
#(
   parameter bit HAS_SYNC_CHECK = 1'b1,
   parameter bit HAS_MEM_CHECK = 1'b1
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic [7:0] tape_line_count,
   input wire logic tape_load_done,
   input wire logic [7:0] direct_line_count,
   input wire logic direct_load_active,
   input wire logic direct_tof_error,
   input wire logic direct_data_error,
   input wire logic skip_prefix_seen,
   input wire logic alternate_line_skip_mode,
   input wire logic print_sync_lost,
   input wire logic memory_error,
   output logic [7:0] status_code,
   output logic fault
);
   logic [7:0] code_ff;
   logic [7:0] nxt_code;
   wire tape_long = tape_load_done && (tape_line_count > `PPH_MAX_FORMAT_LINES);
   wire da_long = direct_load_active && (direct_line_count > `PPH_MAX_FORMAT_LINES);
   wire da_tof = direct_load_active && direct_tof_error;
   wire da_data = direct_load_active && direct_data_error;
   wire skip_bad = skip_prefix_seen && alternate_line_skip_mode;
   wire sync_bad = HAS_SYNC_CHECK && print_sync_lost;
   wire mem_bad = HAS_MEM_CHECK && memory_error;
   // A new fault wins over a clear in the same cycle so no event is lost.
   assign nxt_code = tape_long ? `PPH_ST_TAPE_LONG : // [R14]
                     da_long ? `PPH_ST_DA_LONG : // [R15]
                     da_tof ? `PPH_ST_DA_TOF : // [R16]
                     da_data ? `PPH_ST_DA_DATA : // [R16]
                     skip_bad ? `PPH_ST_SKIP_IN_ALT : // [R17]
                     sync_bad ? `PPH_ST_SYNC_LOSS : // [R18]
                     mem_bad ? `PPH_ST_MEM_ERR : // [R18]
                     clear ? `PPH_ST_NONE : code_ff;
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         code_ff <= `PPH_ST_NONE;
      end
      else
      begin
         code_ff <= nxt_code;
      end
   end
   assign status_code = code_ff;
   assign fault = (code_ff != `PPH_ST_NONE);
endmodule

// ===== pph_host_port_props.sv
// Concurrent checks on the ports of the parallel printer host port.
`timescale 1ns/1ps
module pph_host_port_props
#(
   parameter int ACK_CYCLES = 500
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic busy,
   input wire logic data_demand_n,
   input wire logic ack_n,
   input wire logic selected_indication,
   input wire logic fault_n,
   input wire logic paper_empty,
   input wire logic register_bus_oe_n,
   input wire logic user_port_enable_n,
   input wire logic user_latch_read_decode_n,
   input wire logic control_group_zero_decode_n,
   input wire logic [2:0] addr_10_12,
   input wire logic init_printer,
   input wire logic [7:0] status_code
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   int low_ff;
   logic pe_bit;
   assign pe_bit = addr_10_12[0];
   always_ff @(posedge clock)
   begin
      low_ff <= (rst || ack_n) ? 0 : low_ff + 1;
   end
   // Fault with no code can only be self-test; three cycles ride out any lag between the two registers.
   sequence in_test_s;
      (!fault_n && status_code == 8'h00) [*3];
   endsequence
   AST_DEMAND: assert property (data_demand_n == busy) else $error("demand differs from busy");
   AST_PE_WRITE: assert property (!control_group_zero_decode_n && addr_10_12[2:1] == 2'h3 |=> paper_empty == $past(pe_bit))
      else $error("paper empty write lost");
   AST_BUS_OE: assert property (register_bus_oe_n == (user_port_enable_n | user_latch_read_decode_n))
      else $error("bus enable wrong");
   AST_ACK_NOT_BUSY: assert property ($fell(ack_n) |-> !busy) else $error("ack while busy");
   AST_ACK_WIDTH: assert property ($rose(ack_n) |-> low_ff == ACK_CYCLES) else $error("ack width wrong");
   AST_RESET_LEVELS: assert property ($fell(rst) |-> busy && paper_empty && ack_n && !selected_indication && fault_n)
      else $error("reset levels wrong");
   AST_TEST_BUSY: assert property (in_test_s |-> busy) else $error("busy low in self-test");
   AST_TEST_NO_ACK: assert property (in_test_s |-> ack_n) else $error("ack in self-test");
   AST_TEST_UNSELECTED: assert property (in_test_s |-> !selected_indication) else $error("selected in self-test");
   AST_INIT_ONE_SHOT: assert property (init_printer |=> !init_printer) else $error("init pulse too long");
   cover property ($fell(ack_n));
   cover property ($rose(selected_indication));
   cover property (in_test_s);
   cover property (init_printer);
endmodule
bind pph_host_port pph_host_port_props #(.ACK_CYCLES(ACK_CYCLES)) u_pph_host_port_props
(
   .clock, .rst, .busy, .data_demand_n, .ack_n, .selected_indication, .fault_n, .paper_empty,
   .register_bus_oe_n, .user_port_enable_n, .user_latch_read_decode_n, .control_group_zero_decode_n,
   .addr_10_12, .init_printer, .status_code
);

// ===== pph_host_model.sv
// Host computer model driving bytes, strobe and init prime.
`timescale 1ns/1ps
module pph_host_model
(
   input wire logic clock,
   input wire logic ack_n,
   output logic [7:0] host_data_n,
   output logic host_strobe_n,
   output logic host_init_prime_n
);
   initial
   begin
      host_data_n = 8'h00;
      host_strobe_n = 1'b1;
      host_init_prime_n = 1'b1;
   end
   task wait_ack(input int lim, output bit acked);
      int n;
      acked = 1'b0;
      for (n = 0; n < lim && !acked; n++)
      begin
         @(posedge clock);
         acked = (ack_n === 1'b0);
      end
      for (n = 0; n < 600 && acked && ack_n !== 1'b1; n++)
      begin
         @(posedge clock);
      end
   endtask
   task send(input logic [7:0] b, input int lim, output bit acked);
      @(posedge clock);
      host_data_n <= ~b;
      @(posedge clock);
      host_strobe_n <= 1'b0;
      repeat (4) @(posedge clock);
      host_strobe_n <= 1'b1;
      wait_ack(lim, acked);
      // Stale data is scrambled so a lucky held value cannot mask a late sample.
      if (acked)
      begin
         host_data_n <= b;
      end
   endtask
   task prime;
      @(posedge clock);
      host_init_prime_n <= 1'b0;
      repeat (4) @(posedge clock);
      host_init_prime_n <= 1'b1;
      repeat (6) @(posedge clock);
   endtask
endmodule

// ===== pph_host_port_tb.sv
// Self-checking bench for the parallel printer host port.
`timescale 1ns/1ps
module pph_host_port_tb;
   logic clock, rst, init_prime_enable_switch, online_switch, alarm_clear_switch, test_switch, busy_set;
   logic busy_release, user_port_enable_n, user_latch_read_decode_n, control_group_zero_decode_n;
   logic tape_load_done, direct_load_active, direct_tof_error, direct_data_error, alternate_line_skip_mode;
   logic print_sync_lost, memory_error, host_strobe_n, host_init_prime_n, busy, data_demand_n, ack_n;
   logic selected_indication, fault_n, paper_empty, register_bus_oe_n, data_ready, init_printer;
   logic [7:0] host_data_n, tape_line_count, direct_line_count, register_bus, status_code, b;
   logic [2:0] addr_10_12;
   logic [31:0] seed;
   logic [7:0] q[$];
   localparam logic [7:0] CODES[6] = '{8'h13, 8'h27, 8'h29, 8'h31, 8'h17, 8'h34};
   int failures, checked, inits, n0;
   bit ok, stall, rdy_q;
   pph_host_port #(.ACK_CYCLES(4)) u_pph_host_port
   (
      .clock, .rst, .host_data_n, .host_strobe_n, .host_init_prime_n, .init_prime_enable_switch, .online_switch,
      .alarm_clear_switch, .test_switch, .busy_set, .busy_release, .user_port_enable_n, .user_latch_read_decode_n,
      .control_group_zero_decode_n, .addr_10_12, .tape_line_count, .tape_load_done, .direct_line_count,
      .direct_load_active, .direct_tof_error, .direct_data_error, .alternate_line_skip_mode, .print_sync_lost,
      .memory_error, .busy, .data_demand_n, .ack_n, .selected_indication, .fault_n, .paper_empty, .register_bus,
      .register_bus_oe_n, .data_ready, .init_printer, .status_code
   );
   pph_host_model u_pph_host_model (.clock, .ack_n, .host_data_n, .host_strobe_n, .host_init_prime_n);
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("Counts: %0d checked, %0d failures", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task press(input bit alarm);
      @(posedge clock);
      online_switch <= !alarm;
      alarm_clear_switch <= alarm;
      repeat (4) @(posedge clock);
      online_switch <= 1'b0;
      alarm_clear_switch <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   task causes(input logic [5:0] oh, input logic [7:0] cnt);
      @(posedge clock);
      tape_line_count <= cnt;
      tape_load_done <= oh[0];
      direct_load_active <= |oh[3:1];
      direct_line_count <= oh[1] ? 8'h7f : 8'h7e;
      direct_tof_error <= oh[2];
      direct_data_error <= oh[3];
      print_sync_lost <= oh[4];
      memory_error <= oh[5];
      repeat (8) @(posedge clock);
   endtask
   // Processor side: releases busy unless stalled, reads each forwarded byte, checks it against the oldest note when one is queued.
   always @(posedge clock)
   begin
      busy_release <= busy && !busy_release && !stall;
      user_port_enable_n <= !data_ready;
      user_latch_read_decode_n <= !data_ready;
      rdy_q <= data_ready;
      if (init_printer === 1'b1)
         inits <= inits + 1;
      if (data_ready === 1'b1 && !rdy_q && q.size() > 0)
         chk(register_bus, q.pop_front());
   end
   initial
   begin
      #900000;
      failures++;
      end_sim;
   end
   initial
   begin
      {rst, stall, user_port_enable_n, user_latch_read_decode_n, control_group_zero_decode_n} = 5'h1f;
      {init_prime_enable_switch, online_switch, alarm_clear_switch, test_switch, busy_set, busy_release} = 6'h00;
      {tape_load_done, direct_load_active, direct_tof_error, direct_data_error} = 4'h0;
      {alternate_line_skip_mode, print_sync_lost, memory_error, addr_10_12} = 6'h00;
      {tape_line_count, direct_line_count, seed} = {16'h0000, 32'h00000054};
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      chk(8'({busy, paper_empty, selected_indication}), 8'h06);
      u_pph_host_model.send(8'h41, 30, ok);
      chk(8'(ok), 8'h00);
      u_pph_host_model.send(8'h11, 30, ok);
      chk(8'({selected_indication, ok}), 8'h02);
      stall <= 1'b0;
      u_pph_host_model.wait_ack(40, ok);
      chk(8'(ok), 8'h01);
      $display("remote select test done");
      repeat (6)
      begin
         seed = xs(seed);
         b = 8'h20 + 8'(seed % 95);
         q.push_back(b);
         u_pph_host_model.send(b, 40, ok);
         chk(8'(ok), 8'h01);
      end
      chk(8'(q.size()), 8'h00);
      $display("data transfer test done");
      alternate_line_skip_mode <= 1'b1;
      u_pph_host_model.send(8'h1f, 40, ok);
      chk(status_code, 8'h32);
      alternate_line_skip_mode <= 1'b0;
      n0 = inits;
      u_pph_host_model.prime;
      chk(8'({status_code == 8'h32, inits == n0}), 8'h03);
      init_prime_enable_switch <= 1'b1;
      u_pph_host_model.prime;
      chk(8'({status_code, inits == n0 + 1}), 8'h01);
      press(1'b1);
      chk(8'(inits - n0), 8'h02);
      $display("init prime test done");
      u_pph_host_model.send(8'h13, 40, ok);
      chk(8'(selected_indication), 8'h00);
      press(1'b0);
      chk(8'(selected_indication), 8'h01);
      u_pph_host_model.send(8'h13, 40, ok);
      control_group_zero_decode_n <= 1'b0;
      addr_10_12 <= 3'h6;
      repeat (2) @(posedge clock);
      chk(8'(paper_empty), 8'h00);
      addr_10_12 <= 3'h7;
      repeat (2) @(posedge clock);
      control_group_zero_decode_n <= 1'b1;
      chk(8'(paper_empty), 8'h01);
      test_switch <= 1'b1;
      repeat (8) @(posedge clock);
      chk(8'({busy, fault_n}), 8'h02);
      u_pph_host_model.send(8'h11, 30, ok);
      chk(8'({ok, selected_indication}), 8'h00);
      test_switch <= 1'b0;
      repeat (8) @(posedge clock);
      chk(8'(busy), 8'h01);
      press(1'b0);
      chk(8'({selected_indication, fault_n}), 8'h01);
      u_pph_host_model.send(8'h11, 40, ok);
      test_switch <= 1'b1;
      repeat (8) @(posedge clock);
      chk(8'({selected_indication, fault_n}), 8'h03);
      test_switch <= 1'b0;
      u_pph_host_model.send(8'h13, 40, ok);
      $display("self-test test done");
      causes(6'h01, 8'h7e);
      chk(status_code, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         causes(6'h01 << i, 8'h7f);
         chk(status_code, CODES[i]);
         causes(6'h00, 8'h7f);
         u_pph_host_model.send(8'h11, 20, ok);
         chk(8'({selected_indication, fault_n}), 8'h00);
         press(1'b1);
         chk(status_code, 8'h00);
      end
      $display("status test done");
      end_sim;
   end
endmodule
